/* File: include/crossbar_pkg.sv */
/*
 * constants, signal indices and carrier types shared by the priority pin crossbar and its pin cells.
 * assumes a single system clock domain and a synchronous active-high reset.
 */
package crossbar_pkg;

	// ************************************************************
	// pin geometry
	// ************************************************************
	localparam int PIN_COUNT_LARGE = 40; // larger package option
	localparam int PIN_COUNT_SMALL = 25; // smaller package option
	localparam int PIN_SLOTS = 40; // width of every pin vector except the 32-bit skip mask
	localparam int XBAR_PINS = 32; // first four ports reachable by the crossbar
	localparam int PIN_IDX_W = 6;
	localparam logic [PIN_IDX_W-1:0] FIRST_SERIAL_PORT_TX_PIN = 6'h04;
	localparam logic [PIN_IDX_W-1:0] FIRST_SERIAL_PORT_RX_PIN = 6'h05;

	// ************************************************************
	// peripheral signals in priority order, highest first
	// ************************************************************
	localparam int SIG_COUNT = 15;
	localparam int SIG_IDX_W = 4;
	localparam logic [SIG_IDX_W-1:0] SIG_U0TX = 4'h0;
	localparam logic [SIG_IDX_W-1:0] SIG_U0RX = 4'h1;
	localparam logic [SIG_IDX_W-1:0] SIG_SCK = 4'h2;
	localparam logic [SIG_IDX_W-1:0] SIG_MISO = 4'h3;
	localparam logic [SIG_IDX_W-1:0] SIG_MOSI = 4'h4;
	localparam logic [SIG_IDX_W-1:0] SIG_NSS = 4'h5;
	localparam logic [SIG_IDX_W-1:0] SIG_SDA = 4'h6;
	localparam logic [SIG_IDX_W-1:0] SIG_SCL = 4'h7;
	localparam logic [SIG_IDX_W-1:0] SIG_CP0 = 4'h8;
	localparam logic [SIG_IDX_W-1:0] SIG_CP0A = 4'h9;
	localparam logic [SIG_IDX_W-1:0] SIG_CP1 = 4'hA;
	localparam logic [SIG_IDX_W-1:0] SIG_CP1A = 4'hB;
	localparam logic [SIG_IDX_W-1:0] SIG_SYSCLK = 4'hC;
	localparam logic [SIG_IDX_W-1:0] SIG_U1TX = 4'hD;
	localparam logic [SIG_IDX_W-1:0] SIG_U1RX = 4'hE;
	localparam logic [SIG_COUNT-1:0] PAIR_FIRST_MASK = 15'h2040; // sda, second uart tx
	localparam logic [SIG_COUNT-1:0] PAIR_SECOND_MASK = 15'h4080; // scl, second uart rx

	// ************************************************************
	// select bit positions
	// ************************************************************
	localparam int SEL_A_FIRST_SERIAL_PORT = 0;
	localparam int SEL_A_SPI = 1;
	localparam int SEL_A_SMB = 2;
	localparam int SEL_A_SYSCLK = 3;
	localparam int SEL_A_CP0 = 4;
	localparam int SEL_A_CP0A = 5;
	localparam int SEL_A_CP1 = 6;
	localparam int SEL_A_CP1A = 7;
	localparam int SEL_B_XBAR_EN = 6;
	localparam int SEL_C_UART1 = 0;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [PIN_SLOTS-1:0] PIN_VEC_RST = 40'h00_0000_0000;
	localparam logic [SIG_COUNT-1:0] SIG_VEC_RST = 15'h0000;
	localparam logic [SIG_COUNT-1:0] PERIPH_IN_RST = 15'h7FFF; // unrouted inputs idle high

	typedef struct packed {
		logic [SIG_COUNT-1:0] out;
		logic [SIG_COUNT-1:0] oe;
	} periph_drive_t;

	typedef struct packed {
		logic own;
		logic own_out;
		logic own_oe;
		logic force_od;
		logic gpio_out;
		logic gpio_oe;
		logic push_pull;
		logic digital;
		logic blocked;
	} cell_ctl_t;

endpackage

/* File: hw/pin_drive_cell.sv */
/*
 * one port pin output stage: picks crossbar or port-latch drive and applies push-pull or open-drain.
 * assumes control inputs are synchronous to the same clock; the crossbar registers only the routing map and enable.
 */
`timescale 1ns/1ps
module pin_drive_cell (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire crossbar_pkg::cell_ctl_t ctl, // drive selection for this pin
	output logic pin_out, // registered output level
	output logic pin_oe // registered output enable, high while driving
);

	// ************************************************************
	// drive selection
	// ************************************************************
	logic out_r;
	logic oe_r;
	logic drv_out;
	logic drv_oe;
	logic open_drain;

	// open-drain only ever pulls low, so a high level releases the pin
	assign drv_out = ctl.own ? ctl.own_out : ctl.gpio_out;
	assign drv_oe = ctl.own ? ctl.own_oe : ctl.gpio_oe;
	assign open_drain = ctl.force_od || !ctl.push_pull;

	// analog pins and, on pins 0 to 31, a disabled crossbar both keep the driver off
	always_ff @(posedge clk) begin
		if (rst) begin
			out_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			oe_r <= ctl.digital && !ctl.blocked && drv_oe && (!open_drain || !drv_out);
			out_r <= drv_out && !open_drain;
		end
	end

	assign pin_out = out_r;
	assign pin_oe = oe_r;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	od_mode_a: assert property (oe_r && out_r |-> $past(ctl.push_pull) && !$past(ctl.force_od))
		else $error("high drive on an open-drain pin");
	analog_off_a: assert property (!ctl.digital |=> !oe_r)
		else $error("analog pin driven");

endmodule

/* File: hw/priority_pin_crossbar.sv */
/*
 * priority crossbar placing selected peripheral signals on the lowest free port pins, plus pin sync
 * and readback. assumes software supplies select, skip and mode bits as steady levels on this clock.
 */
`timescale 1ns/1ps
// Summary of operation
// - every peripheral signal has a fixed rank, first uart highest, and pins are handed out in rank order.
// - a selected signal gets the lowest-numbered pin still free at its point in the walk.
// - the first uart, when selected, always sits on pins 4 and 5 of the first port.
// - a pin already given to a higher-ranked signal is passed over.
// - a skipped pin is treated as taken and the walk moves on.
// - only pins 0 to 31 can carry peripheral signals; the rest are plain port pins.
// - every pin's level is readable at all times regardless of routing.
// - every pin can be set digital or analog.
// - each pin drives push-pull or open-drain as its output mode bit says, across all five ports, except that sda and scl pins are always open-drain.
// - the pin count is a parameter, 40 or 25.
// - two-wire bus and uart signals are claimed as a pair or not at all.
// - with the master enable clear, pins 0 to 31 stay plain inputs with drivers off.
// - the fifth port is always plain port i/o.
// - pins left after placement serve as plain port i/o in order.
module priority_pin_crossbar #(
	parameter int N_PINS = crossbar_pkg::PIN_COUNT_LARGE
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic [7:0] peripheral_select_a, // first_serial_port, spi, smbus, sysclk, comparators
	input wire logic [7:0] peripheral_select_b, // bit 6 is the master enable
	input wire logic [7:0] peripheral_select_c, // bit 0 second uart
	input wire logic spi_nss_enable, // route nss in four-wire mode
	input wire logic [crossbar_pkg::XBAR_PINS-1:0] pin_skip_mask, // skip per crossbar pin
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] output_drive_mode, // 1 push-pull, 0 open-drain
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] input_mode_digital, // 1 digital, 0 analog
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] gpio_out, // port latch levels
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] gpio_oe, // port latch drive request
	input wire crossbar_pkg::periph_drive_t periph_drive, // peripheral outputs and enables
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] pin_in, // pad levels, asynchronous
	output logic [crossbar_pkg::PIN_SLOTS-1:0] pin_out, // pad output level
	output logic [crossbar_pkg::PIN_SLOTS-1:0] pin_oe, // pad output enable
	output logic [crossbar_pkg::PIN_SLOTS-1:0] port_level, // synchronised pin readback
	output logic [crossbar_pkg::SIG_COUNT-1:0] periph_in, // pin levels seen by peripherals
	output logic [crossbar_pkg::SIG_COUNT-1:0] sig_routed // signal has a pin
);

	// ************************************************************
	// selection decode
	// ************************************************************
	logic routing_master_enable;
	logic [crossbar_pkg::SIG_COUNT-1:0] sig_en;
	logic [crossbar_pkg::PIN_SLOTS-1:0] skip_full;

	assign routing_master_enable = peripheral_select_b[crossbar_pkg::SEL_B_XBAR_EN];
	assign skip_full = {8'h00, pin_skip_mask};
	// bit order of sig_en is the priority order
	assign sig_en = {{2{peripheral_select_c[crossbar_pkg::SEL_C_UART1]}},
		peripheral_select_a[crossbar_pkg::SEL_A_SYSCLK],
		peripheral_select_a[crossbar_pkg::SEL_A_CP1A],
		peripheral_select_a[crossbar_pkg::SEL_A_CP1],
		peripheral_select_a[crossbar_pkg::SEL_A_CP0A],
		peripheral_select_a[crossbar_pkg::SEL_A_CP0],
		{2{peripheral_select_a[crossbar_pkg::SEL_A_SMB]}},
		peripheral_select_a[crossbar_pkg::SEL_A_SPI] && spi_nss_enable,
		{3{peripheral_select_a[crossbar_pkg::SEL_A_SPI]}},
		{2{peripheral_select_a[crossbar_pkg::SEL_A_FIRST_SERIAL_PORT]}}};

	// ************************************************************
	// priority walk
	// ************************************************************
	logic [crossbar_pkg::PIN_SLOTS-1:0] taken;
	logic [crossbar_pkg::PIN_SLOTS-1:0] vld_nxt;
	logic [crossbar_pkg::SIG_IDX_W-1:0] owner_nxt [crossbar_pkg::PIN_SLOTS];
	logic [crossbar_pkg::PIN_IDX_W-1:0] sig_pin_nxt [crossbar_pkg::SIG_COUNT];
	logic [crossbar_pkg::SIG_COUNT-1:0] routed_nxt;
	logic [crossbar_pkg::PIN_SLOTS-1:0] uart_fix_mask;
	int p_a;
	int p_b;
	logic f_a;
	logic f_b;

	// the walk is a pure function of the masks, so any change rebuilds the map next cycle
	always_comb begin
		taken = crossbar_pkg::PIN_VEC_RST;
		vld_nxt = crossbar_pkg::PIN_VEC_RST;
		routed_nxt = crossbar_pkg::SIG_VEC_RST;
		uart_fix_mask = crossbar_pkg::PIN_VEC_RST;
		p_a = 0;
		p_b = 0;
		f_a = 1'b0;
		f_b = 1'b0;
		for (int i = 0; i < crossbar_pkg::PIN_SLOTS; i++) begin
			owner_nxt[i] = crossbar_pkg::SIG_U0TX;
			taken[i] = skip_full[i] || (i >= crossbar_pkg::XBAR_PINS) || (i >= N_PINS);
		end
		for (int s = 0; s < crossbar_pkg::SIG_COUNT; s++) begin
			sig_pin_nxt[s] = crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN;
		end
		// fixed pins override skip bits, as the boot path depends on them
		if (routing_master_enable && sig_en[crossbar_pkg::SIG_U0TX]) begin
			uart_fix_mask[crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN] = 1'b1;
			uart_fix_mask[crossbar_pkg::FIRST_SERIAL_PORT_RX_PIN] = 1'b1;
			taken[crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN] = 1'b1;
			taken[crossbar_pkg::FIRST_SERIAL_PORT_RX_PIN] = 1'b1;
			vld_nxt[crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN] = 1'b1;
			vld_nxt[crossbar_pkg::FIRST_SERIAL_PORT_RX_PIN] = 1'b1;
			owner_nxt[crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN] = crossbar_pkg::SIG_U0TX;
			owner_nxt[crossbar_pkg::FIRST_SERIAL_PORT_RX_PIN] = crossbar_pkg::SIG_U0RX;
			sig_pin_nxt[crossbar_pkg::SIG_U0TX] = crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN;
			sig_pin_nxt[crossbar_pkg::SIG_U0RX] = crossbar_pkg::FIRST_SERIAL_PORT_RX_PIN;
			routed_nxt[crossbar_pkg::SIG_U0TX] = 1'b1;
			routed_nxt[crossbar_pkg::SIG_U0RX] = 1'b1;
		end
		for (int s = 2; s < crossbar_pkg::SIG_COUNT; s++) begin
			if (routing_master_enable && sig_en[s] && !crossbar_pkg::PAIR_SECOND_MASK[s]) begin
				f_a = 1'b0;
				for (int i = 0; i < crossbar_pkg::PIN_SLOTS; i++) begin
					if (!f_a && !taken[i]) begin
						p_a = i;
						f_a = 1'b1;
					end
				end
				f_b = !crossbar_pkg::PAIR_FIRST_MASK[s];
				for (int i = 0; i < crossbar_pkg::PIN_SLOTS; i++) begin
					if (!f_b && !taken[i] && (i != p_a)) begin
						p_b = i;
						f_b = 1'b1;
					end
				end
				// a lone free pin cannot hold a pair, so the pair stays unrouted
				if (f_a && f_b) begin
					taken[p_a] = 1'b1;
					vld_nxt[p_a] = 1'b1;
					owner_nxt[p_a] = crossbar_pkg::SIG_IDX_W'(s);
					sig_pin_nxt[s] = crossbar_pkg::PIN_IDX_W'(p_a);
					routed_nxt[s] = 1'b1;
					if (crossbar_pkg::PAIR_FIRST_MASK[s]) begin
						taken[p_b] = 1'b1;
						vld_nxt[p_b] = 1'b1;
						owner_nxt[p_b] = crossbar_pkg::SIG_IDX_W'(s + 1);
						sig_pin_nxt[s + 1] = crossbar_pkg::PIN_IDX_W'(p_b);
						routed_nxt[s + 1] = 1'b1;
					end
				end
			end
		end
	end

	// ************************************************************
	// registered map
	// ************************************************************
	logic [crossbar_pkg::PIN_SLOTS-1:0] vld_r;
	logic [crossbar_pkg::SIG_IDX_W-1:0] owner_r [crossbar_pkg::PIN_SLOTS];
	logic [crossbar_pkg::PIN_IDX_W-1:0] sig_pin_r [crossbar_pkg::SIG_COUNT];
	logic [crossbar_pkg::SIG_COUNT-1:0] routed_r;
	logic [crossbar_pkg::PIN_SLOTS-1:0] skip_r;
	logic en_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			vld_r <= crossbar_pkg::PIN_VEC_RST;
			routed_r <= crossbar_pkg::SIG_VEC_RST;
			skip_r <= crossbar_pkg::PIN_VEC_RST;
			en_r <= 1'b0;
			for (int i = 0; i < crossbar_pkg::PIN_SLOTS; i++) begin
				owner_r[i] <= crossbar_pkg::SIG_U0TX;
			end
			for (int s = 0; s < crossbar_pkg::SIG_COUNT; s++) begin
				sig_pin_r[s] <= crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN;
			end
		end else begin
			vld_r <= vld_nxt;
			routed_r <= routed_nxt;
			skip_r <= skip_full & ~uart_fix_mask;
			en_r <= routing_master_enable;
			owner_r <= owner_nxt;
			sig_pin_r <= sig_pin_nxt;
		end
	end

	assign sig_routed = routed_r;

	// ************************************************************
	// pin input sync and readback
	// ************************************************************
	logic [crossbar_pkg::PIN_SLOTS-1:0] sync1_r;
	logic [crossbar_pkg::PIN_SLOTS-1:0] sync2_r;
	logic [crossbar_pkg::PIN_SLOTS-1:0] level_r;

	// two stages against metastability, then a readback register
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_r <= crossbar_pkg::PIN_VEC_RST;
			sync2_r <= crossbar_pkg::PIN_VEC_RST;
			level_r <= crossbar_pkg::PIN_VEC_RST;
		end else begin
			sync1_r <= pin_in;
			sync2_r <= sync1_r;
			level_r <= sync2_r;
		end
	end

	assign port_level = level_r;

	// ************************************************************
	// per-pin drive and per-signal input return
	// ************************************************************
	logic [crossbar_pkg::SIG_COUNT-1:0] periph_in_r;

	for (genvar g = 0; g < crossbar_pkg::PIN_SLOTS; g++) begin : g_pin
		crossbar_pkg::cell_ctl_t ctl;
		assign ctl.own = vld_r[g];
		assign ctl.own_out = periph_drive.out[owner_r[g]];
		assign ctl.own_oe = periph_drive.oe[owner_r[g]];
		// the two-wire bus is open-drain whatever the mode bit says
		assign ctl.force_od = vld_r[g] && ((owner_r[g] == crossbar_pkg::SIG_SDA) || (owner_r[g] == crossbar_pkg::SIG_SCL));
		assign ctl.gpio_out = gpio_out[g];
		assign ctl.gpio_oe = gpio_oe[g];
		assign ctl.push_pull = output_drive_mode[g];
		assign ctl.digital = input_mode_digital[g] && (g < N_PINS);
		assign ctl.blocked = (g < crossbar_pkg::XBAR_PINS) ? !en_r : 1'b0;
		pin_drive_cell u_cell (
			.clk(clk),
			.rst(rst),
			.ctl(ctl),
			.pin_out(pin_out[g]),
			.pin_oe(pin_oe[g])
		);
	end

	for (genvar s = 0; s < crossbar_pkg::SIG_COUNT; s++) begin : g_sig
		always_ff @(posedge clk) begin
			if (rst) begin
				periph_in_r[s] <= crossbar_pkg::PERIPH_IN_RST[s];
			end else begin
				periph_in_r[s] <= routed_r[s] ? sync2_r[sig_pin_r[s]] : 1'b1;
			end
		end
	end

	assign periph_in = periph_in_r;

	// ************************************************************
	// checks
	// ************************************************************
	logic order_bad;
	logic gap_bad;
	logic free_seen;
	logic [crossbar_pkg::SIG_IDX_W-1:0] last_owner;
	logic any_owner;

	// owners other than the fixed first uart must rise with pin number and leave no free pin beneath
	always_comb begin
		order_bad = 1'b0;
		gap_bad = 1'b0;
		free_seen = 1'b0;
		any_owner = 1'b0;
		last_owner = crossbar_pkg::SIG_U0TX;
		for (int i = 0; i < crossbar_pkg::XBAR_PINS; i++) begin
			if (vld_r[i] && (owner_r[i] > crossbar_pkg::SIG_U0RX)) begin
				if (any_owner && (owner_r[i] <= last_owner)) begin
					order_bad = 1'b1;
				end
				if (free_seen) begin
					gap_bad = 1'b1;
				end
				any_owner = 1'b1;
				last_owner = owner_r[i];
			end else if (!vld_r[i] && !skip_r[i] && (i < N_PINS)) begin
				free_seen = 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence first_serial_port_req;
		routing_master_enable && sig_en[crossbar_pkg::SIG_U0TX];
	endsequence

	sequence first_serial_port_placed;
		vld_r[crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN] && (owner_r[crossbar_pkg::FIRST_SERIAL_PORT_TX_PIN] == crossbar_pkg::SIG_U0TX)
			&& vld_r[crossbar_pkg::FIRST_SERIAL_PORT_RX_PIN] && (owner_r[crossbar_pkg::FIRST_SERIAL_PORT_RX_PIN] == crossbar_pkg::SIG_U0RX);
	endsequence

	uart_fixed_a: assert property (first_serial_port_req |=> first_serial_port_placed)
		else $error("first uart not on its fixed pins");
	disabled_hiz_a: assert property (!routing_master_enable |-> ##2 (pin_oe[crossbar_pkg::XBAR_PINS-1:0] == 32'h0000_0000))
		else $error("crossbar pin driven while disabled");
	skip_respected_a: assert property ((vld_r & skip_r) == crossbar_pkg::PIN_VEC_RST)
		else $error("skipped pin was routed");
	port4_gpio_a: assert property (vld_r[crossbar_pkg::PIN_SLOTS-1:crossbar_pkg::XBAR_PINS] == 8'h00)
		else $error("fifth port pin routed");
	pairs_together_a: assert property ((routed_r[crossbar_pkg::SIG_SDA] == routed_r[crossbar_pkg::SIG_SCL])
		&& (routed_r[crossbar_pkg::SIG_U1TX] == routed_r[crossbar_pkg::SIG_U1RX]))
		else $error("paired signals split");
	prio_order_a: assert property (!order_bad)
		else $error("pins not in priority order");
	no_gap_a: assert property (!gap_bad)
		else $error("free pin left below a routed one");
	level_read_a: assert property (!$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3) |-> port_level == $past(pin_in, 3))
		else $error("pin readback wrong");

endmodule

/* File: verification/pad_board_model.sv */
/*
 * board-side model of the forty pads around the priority pin crossbar.
 * assumes the crossbar drives pin_out/pin_oe and the bench supplies the level the board
 * holds on a pad that nobody drives.
 */
`timescale 1ns/1ps
module pad_board_model (
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] pin_out, // pad level from the crossbar
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] pin_oe, // high while the crossbar drives
	input wire logic [crossbar_pkg::PIN_SLOTS-1:0] ext_level, // board level on a released pad
	output logic [crossbar_pkg::PIN_SLOTS-1:0] pin_in // resolved pad level
);
	// a released pad shows the board level, never the last driven value
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: verification/test_priority_pin_crossbar.sv */
/*
 * self-checking bench for the priority pin crossbar: a table of configurations, each checked against
 * a reference walk kept here. assumes the pad board model and the crossbar package are compiled first.
 */
`timescale 1ns/1ps
module test_priority_pin_crossbar;
	typedef struct packed {
		logic en;
		logic [7:0] sel_a;
		logic uart1;
		logic nss;
		logic [31:0] skip;
		logic [39:0] mode;
		logic [39:0] dig;
	} scen_t;
	localparam logic [14:0] PD_OUT = 15'h2B4D;
	localparam logic [14:0] PD_OE = 15'h3FFD; // receive-only lines never drive
	localparam logic [39:0] GPIO_LVL = 40'hC3_5A96_A53C;
	localparam logic [39:0] EXT_LVL = 40'h96_3C5A_0FF0;
	logic clk, rst, nss_en;
	logic [7:0] sel_a, sel_b, sel_c;
	logic [31:0] skip;
	logic [39:0] mode, dig, g_out, g_oe, ext, pin_in, pin_out, pin_oe, port_level;
	logic [14:0] periph_in, sig_routed, exp_routed, exp_pin_in;
	logic [39:0] exp_oe, exp_out, exp_pad;
	crossbar_pkg::periph_drive_t pdrv;
	int error_cnt, n_tests;
	scen_t scen [6];

	priority_pin_crossbar #(.N_PINS(crossbar_pkg::PIN_COUNT_LARGE)) uut (.clk(clk), .rst(rst),
		.peripheral_select_a(sel_a), .peripheral_select_b(sel_b), .peripheral_select_c(sel_c),
		.spi_nss_enable(nss_en), .pin_skip_mask(skip), .output_drive_mode(mode), .input_mode_digital(dig),
		.gpio_out(g_out), .gpio_oe(g_oe), .periph_drive(pdrv), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .port_level(port_level), .periph_in(periph_in), .sig_routed(sig_routed));
	pad_board_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

	// 100 MHz system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ************************************************************
	// checking and reference walk
	// ************************************************************
	task check(input string name, input logic [39:0] seen, input logic [39:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	function automatic int next_free(input logic [39:0] taken, input int from);
		for (int p = from; p < 32; p++) begin
			if (!taken[p]) return p;
		end
		return -1;
	endfunction

	// walk in rank order; a pair that cannot get two pins leaves its lone pin for later singles
	task compute(input scen_t s);
		logic [14:0] want;
		logic [39:0] taken;
		int p1, p2;
		int owner [40];
		logic od, lvl, req;
		want = {{2{s.uart1}}, s.sel_a[3], s.sel_a[7:4], {2{s.sel_a[2]}}, s.sel_a[1] & s.nss,
			{3{s.sel_a[1]}}, {2{s.sel_a[0]}}} & {15{s.en}};
		taken = {8'hFF, s.skip};
		exp_routed = '0;
		exp_pin_in = '1;
		foreach (owner[p]) owner[p] = -1;
		if (want[0]) begin
			taken[5:4] = 2'b11;
			owner[4] = 0;
			owner[5] = 1;
			exp_routed[1:0] = 2'b11;
		end
		for (int i = 2; i < 15; i++) begin
			if (!want[i] || i == 7 || i == 14) continue;
			p1 = next_free(taken, 0);
			p2 = (i == 6 || i == 13) ? ((p1 < 0) ? -1 : next_free(taken, p1 + 1)) : p1;
			if (p1 >= 0 && p2 >= 0) begin
				taken[p1] = 1'b1;
				taken[p2] = 1'b1;
				owner[p1] = i;
				exp_routed[i] = 1'b1;
				if (p2 != p1) begin
					owner[p2] = i + 1;
					exp_routed[i + 1] = 1'b1;
				end
			end
		end
		for (int p = 0; p < 40; p++) begin
			if (owner[p] >= 0) begin
				lvl = PD_OUT[owner[p]];
				req = PD_OE[owner[p]];
				od = !s.mode[p] || owner[p] == 6 || owner[p] == 7;
			end else begin
				lvl = GPIO_LVL[p];
				req = 1'b1;
				od = !s.mode[p];
			end
			exp_oe[p] = req && (od ? !lvl : 1'b1) && s.dig[p] && (s.en || p >= 32);
			exp_out[p] = od ? 1'b0 : lvl;
			exp_pad[p] = exp_oe[p] ? exp_out[p] : EXT_LVL[p];
			if (owner[p] >= 0) exp_pin_in[owner[p]] = exp_pad[p];
		end
	endtask

	// map after one edge, drive after two, synchronised levels once the pads have settled
	task apply(input scen_t s, input int idx);
		@(posedge clk);
		#1;
		sel_a = s.sel_a;
		sel_b = {1'b1, s.en, 6'h15};
		sel_c = {7'h2A, s.uart1};
		nss_en = s.nss;
		skip = s.skip;
		mode = s.mode;
		dig = s.dig;
		compute(s);
		@(posedge clk);
		#1;
		check("sig_routed", {25'h0, sig_routed}, {25'h0, exp_routed});
		@(posedge clk);
		#1;
		check("pin_oe", pin_oe, exp_oe);
		check("pin_out", pin_out & exp_oe, exp_out & exp_oe);
		repeat (4) @(posedge clk);
		#1;
		check("port_level", port_level, exp_pad);
		check("periph_in", {25'h0, periph_in}, {25'h0, exp_pin_in});
		$display("test %0d done", idx);
	endtask

	task finish_test();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		rst = 1'b1;
		{sel_a, sel_b, sel_c, nss_en, skip} = '0;
		mode = '1;
		dig = '1;
		g_out = GPIO_LVL;
		g_oe = '1;
		ext = EXT_LVL;
		pdrv = '{out: PD_OUT, oe: PD_OE};
		error_cnt = 0;
		n_tests = 0;
		scen[0] = '{1'b0, 8'hFF, 1'b1, 1'b1, 32'h0000_0000, 40'hFF_FFFF_FFFF, 40'hFF_FFFF_FFFF};
		scen[1] = '{1'b1, 8'h02, 1'b0, 1'b0, 32'h0000_0000, 40'hFF_FFFF_FFFF, 40'hFF_FFFF_FFFF};
		// skipped pins stand for crystal and conversion-start pins
		scen[2] = '{1'b1, 8'h07, 1'b1, 1'b1, 32'h0000_010D, 40'h5A_F0F0_A5A5, 40'hFF_FFFF_FFFF};
		scen[3] = '{1'b1, 8'hFF, 1'b1, 1'b1, 32'h0000_0000, 40'h00_0000_0000, 40'hFF_FFFF_FFFF};
		scen[4] = '{1'b1, 8'h17, 1'b0, 1'b0, 32'hFFFF_FFC0, 40'hFF_FFFF_FFFF, 40'hFF_FFFF_FFFF};
		scen[5] = '{1'b1, 8'h01, 1'b0, 1'b0, 32'h0000_0030, 40'hFF_FFFF_FFFF, 40'h0F_FFFF_F0FF};
		repeat (20) @(posedge clk);
		#1;
		check("rst pin_oe", pin_oe, 40'h00_0000_0000);
		check("rst sig_routed", {25'h0, sig_routed}, 40'h00_0000_0000);
		check("rst periph_in", {25'h0, periph_in}, 40'h00_0000_7FFF);
		check("rst port_level", port_level, 40'h00_0000_0000);
		rst = 1'b0;
		foreach (scen[i]) apply(scen[i], i);
		finish_test();
	end

	// watchdog: the table needs about 62 cycles, so 2000 means a hang
	initial begin
		repeat (2000) @(posedge clk);
		error_cnt++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
